// >>> pkg/fbm_pkg.sv
// shared constants, types and byte-lane helpers for the port-B bus-matching datapath
// Summary of operation
// R1 - long-word reads move whole 36 bits
// R2 - word/byte reads deliver pieces in order
// R3 - read at new size reloads long word
// R4 - unused output lanes hold last value
// R5 - pieces assembled, last piece commits long word
// R6 - write at new size restarts assembly
// R7 - size code all-high accesses mailboxes
// R8 - mailbox access keeps previous size selection
// R9 - each edge applies registered size selection
// R10 - four byte orders, bits within bytes kept
// R11 - mailbox data is never swapped
// R12 - swap mode latched on first piece
// R13 - reads swap then split; writes assemble then swap
// R14 - four byte parity checks drive error low
// R15 - port-B checks only lanes in use
// R16 - odd/even select sets parity sense
// R17 - port-A mailbox read with generation forces flag high
// R18 - port-B mailbox read with generation forces flag high
// R19 - generation replaces byte msb on reads
// R20 - writes store all nine bits unchanged
// R21 - host holds parity selects stable at load
// R22 - mailbox parity generation leaves contents intact
// R23 - size and endian captured every edge
// R24 - queues hold only complete long words
// R25 - swap codes map to ABCD DCBA CDAB BADC
// R26 - size codes: 00 long, 10 word, 01 byte
package fbm_pkg;

  localparam int LW = 36;
  localparam int BW = 9;
  localparam int FIFO_DEPTH = 4;

  // ******************************************************
  // size and swap encodings
  // ******************************************************
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_MAIL = 2'h3;
  localparam logic [1:0] SW_NONE = 2'h0;
  localparam logic [1:0] SW_REV = 2'h1;
  localparam logic [1:0] SW_HALF = 2'h2;
  localparam logic [1:0] SW_PAIR = 2'h3;
  localparam logic [1:0] CNT_RST = 2'h0;
  localparam logic [35:0] WORD_RST = 36'h0;

  typedef logic [35:0] fbm_lw_t;
  typedef struct packed {
    logic [1:0] code;
    logic big;
  } fbm_size_t;
  localparam fbm_size_t SIZE_RST = '{code: 2'h0, big: 1'h1};

  // ******************************************************
  // helpers
  // ******************************************************
  function automatic fbm_lw_t fbm_swap(input fbm_lw_t d, input logic [1:0] m);
    case (m) // R25 R10
      SW_REV: fbm_swap = {d[8:0], d[17:9], d[26:18], d[35:27]};
      SW_HALF: fbm_swap = {d[17:0], d[35:18]};
      SW_PAIR: fbm_swap = {d[26:18], d[35:27], d[8:0], d[17:9]};
      default: fbm_swap = d;
    endcase
  endfunction : fbm_swap

  function automatic fbm_lw_t fbm_pgen(input fbm_lw_t d, input logic odd);
    fbm_pgen = d;
    for (int i = 0; i < 4; i++)
      fbm_pgen[i*BW+8] = odd ? ~^d[i*BW+:8] : ^d[i*BW+:8]; // R19
  endfunction : fbm_pgen

  function automatic logic [3:0] fbm_perr(input fbm_lw_t d, input logic odd);
    for (int i = 0; i < 4; i++)
      fbm_perr[i] = odd ? ~^d[i*BW+:BW] : ^d[i*BW+:BW]; // R16
  endfunction : fbm_perr

  function automatic logic [3:0] fbm_lanes(input fbm_size_t s);
    case (s.code) // R15
      SZ_WORD: fbm_lanes = s.big ? 4'hc : 4'h3;
      SZ_BYTE: fbm_lanes = s.big ? 4'h8 : 4'h1;
      default: fbm_lanes = 4'hf;
    endcase
  endfunction : fbm_lanes

  function automatic logic [1:0] fbm_last(input logic [1:0] code);
    case (code) // R26
      SZ_WORD: fbm_last = 2'h1;
      SZ_BYTE: fbm_last = 2'h3;
      default: fbm_last = 2'h0;
    endcase
  endfunction : fbm_last

  // long-word byte that sits on a lane for piece k
  function automatic logic [1:0] fbm_src(input fbm_size_t s, input logic [1:0] k,
                                         input logic [1:0] lane);
    case (s.code)
      SZ_WORD: fbm_src = {s.big ? ~k[0] : k[0], lane[0]};
      SZ_BYTE: fbm_src = s.big ? 2'(2'h3 - k) : k;
      default: fbm_src = lane;
    endcase
  endfunction : fbm_src

endpackage : fbm_pkg

// >>> hdl/fbm_top.sv
// port-B bus matching, byte swapping, mailboxes and parity for both ports
`timescale 1ns/1ps

// ******************************************************
// small long-word queue toward port A
// ******************************************************
module fbm_fifo #(
  parameter int W = 36,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [CW-1:0] count_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = count_reg != CW'(DEPTH);
  assign out_valid = count_reg != '0;
  assign out_data = mem[rptr_reg];

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : AW'(wptr_reg + 1'b1);
      if (pop)
        rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : AW'(rptr_reg + 1'b1);
      if (push && !pop)
        count_reg <= CW'(count_reg + 1'b1);
      else if (pop && !push)
        count_reg <= CW'(count_reg - 1'b1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wptr_reg] <= in_data;
  end

  // ******************************************************
  // queue checks
  // ******************************************************
  fifo_bound_a: assert property ( // R24
    @(posedge clk) disable iff (!rst_b) count_reg <= CW'(DEPTH))
    else $error("queue count beyond depth");
  fifo_full_hold_a: assert property ( // R24
    @(posedge clk) disable iff (!rst_b) !in_ready && !pop |=> count_reg == $past(count_reg))
    else $error("full queue accepted a word");
  // an empty queue must have its pointers together
  fifo_ptr_a: assert property ( // R24
    @(posedge clk) disable iff (!rst_b) count_reg == '0 |-> wptr_reg == rptr_reg)
    else $error("empty queue pointers differ");
endmodule : fbm_fifo

// ******************************************************
// top
// ******************************************************
module fbm_top (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic ODD_EVEN,
  input wire logic PORTA_CHIP_SEL_N,
  input wire logic PORTA_XFER_EN,
  input wire logic PORTA_WRITE_NREAD,
  input wire logic PORTA_MAIL_SEL,
  input wire logic PORTA_PARITY_GEN,
  input wire logic [35:0] A_IN,
  output logic [35:0] A_OUT,
  output logic A_OE,
  output logic PORTA_PARITY_ERR_N,
  input wire logic PORTB_CHIP_SEL_N,
  input wire logic PORTB_XFER_EN,
  input wire logic PORTB_WRITE_NREAD,
  input wire logic SIZE_SEL_LO,
  input wire logic SIZE_SEL_HI,
  input wire logic BIG_ENDIAN_SEL_N,
  input wire logic SWAP_SEL_LO,
  input wire logic SWAP_SEL_HI,
  input wire logic PORTB_PARITY_GEN,
  input wire logic [35:0] B_IN,
  output logic [35:0] B_OUT,
  output logic B_OE,
  output logic PORTB_PARITY_ERR_N,
  input wire logic [35:0] QAB_DATA,
  input wire logic QAB_VALID,
  output logic QAB_READY
);
  // ******************************************************
  // state
  // ******************************************************
  fbm_pkg::fbm_size_t size_held_reg;
  fbm_pkg::fbm_size_t prev_size_reg;
  fbm_pkg::fbm_size_t rd_size_reg;
  fbm_pkg::fbm_size_t wr_size_reg;
  logic [1:0] rd_cnt_reg;
  logic [1:0] wr_cnt_reg;
  logic [1:0] wr_swap_reg;
  fbm_pkg::fbm_lw_t rd_word_reg;
  fbm_pkg::fbm_lw_t wr_asm_reg;
  fbm_pkg::fbm_lw_t head_reg;
  logic head_v_reg;
  fbm_pkg::fbm_lw_t mail_ab_reg;
  fbm_pkg::fbm_lw_t mail_ba_reg;
  logic [35:0] a_out_reg;
  logic [35:0] b_out_reg;
  logic a_oe_reg;
  logic b_oe_reg;
  logic perr_a_n_reg;
  logic perr_b_n_reg;
  logic qab_ready_reg;

  // ******************************************************
  // decode
  // ******************************************************
  wire [1:0] swap_pins = {SWAP_SEL_HI, SWAP_SEL_LO};
  wire a_sel = !PORTA_CHIP_SEL_N && PORTA_XFER_EN;
  wire a_rd = a_sel && !PORTA_WRITE_NREAD;
  wire a_wr = a_sel && PORTA_WRITE_NREAD;
  wire b_sel = !PORTB_CHIP_SEL_N && PORTB_XFER_EN;
  wire b_rd = b_sel && !PORTB_WRITE_NREAD;
  wire b_wr = b_sel && PORTB_WRITE_NREAD;
  wire mail = size_held_reg.code == fbm_pkg::SZ_MAIL; // R7
  // mailbox code never disturbs the sizing in progress
  wire fbm_pkg::fbm_size_t eff = mail ? prev_size_reg : size_held_reg; // R8 R9
  wire [1:0] last = fbm_pkg::fbm_last(eff.code);
  wire [3:0] lanes = fbm_pkg::fbm_lanes(eff);
  wire b_mail_rd = b_rd && mail;
  wire b_mail_wr = b_wr && mail;
  wire a_mail_rd = a_rd && PORTA_MAIL_SEL;

  // read side: swap, optional parity, then split
  wire rd_fresh = (rd_cnt_reg == fbm_pkg::CNT_RST) || (eff != rd_size_reg); // R3
  wire rd_go = b_rd && !mail && (!rd_fresh || head_v_reg);
  wire [1:0] rk = rd_fresh ? fbm_pkg::CNT_RST : rd_cnt_reg;
  wire fbm_pkg::fbm_lw_t head_sw = fbm_pkg::fbm_swap(head_reg, swap_pins); // R13 R12
  wire fbm_pkg::fbm_lw_t head_pg = PORTB_PARITY_GEN ?
    fbm_pkg::fbm_pgen(head_sw, ODD_EVEN) : head_sw; // R19
  wire fbm_pkg::fbm_lw_t rd_src = rd_fresh ? head_pg : rd_word_reg; // R2
  wire fbm_pkg::fbm_lw_t mail_b_out = PORTB_PARITY_GEN ?
    fbm_pkg::fbm_pgen(mail_ab_reg, ODD_EVEN) : mail_ab_reg; // R11 R22

  // write side: assemble, then swap on commit
  wire wr_fresh = (wr_cnt_reg == fbm_pkg::CNT_RST) || (eff != wr_size_reg); // R6
  wire [1:0] wk = wr_fresh ? fbm_pkg::CNT_RST : wr_cnt_reg;
  wire fbm_pkg::fbm_lw_t asm_base = wr_fresh ? fbm_pkg::WORD_RST : wr_asm_reg;
  wire [1:0] wswap = wr_fresh ? swap_pins : wr_swap_reg; // R12
  wire commit = b_wr && !mail && (wk == last);
  wire q_in_ready;
  // a full queue refuses only the committing piece
  wire wr_go = b_wr && !mail && (!commit || q_in_ready);
  fbm_pkg::fbm_lw_t asm_new;
  fbm_pkg::fbm_lw_t rd_piece;
  wire fbm_pkg::fbm_lw_t q_push_data = fbm_pkg::fbm_swap(asm_new, wswap); // R13 R5

  always_comb
  begin
    rd_piece = b_out_reg; // R4
    asm_new = asm_base;
    for (int i = 0; i < 4; i++)
    begin
      if (lanes[i])
      begin
        rd_piece[i*9+:9] = rd_src[9*int'(fbm_pkg::fbm_src(eff, rk, 2'(i)))+:9];
        asm_new[9*int'(fbm_pkg::fbm_src(eff, wk, 2'(i)))+:9] = B_IN[i*9+:9]; // R20
      end
    end
  end

  // ******************************************************
  // queue toward port A, drained by port-A reads
  // ******************************************************
  wire fbm_pkg::fbm_lw_t q_out_data;
  wire q_out_valid;
  wire a_q_rd = a_rd && !PORTA_MAIL_SEL;
  fbm_fifo #(
    .W(fbm_pkg::LW),
    .DEPTH(fbm_pkg::FIFO_DEPTH)
  ) u_q_b_to_a (
    .clk(CLK),
    .rst_b(RST_B),
    .in_data(q_push_data),
    .in_valid(commit && wr_go), // R24
    .in_ready(q_in_ready),
    .out_data(q_out_data),
    .out_valid(q_out_valid),
    .out_ready(a_q_rd)
  );
  wire fbm_pkg::fbm_lw_t a_src = PORTA_MAIL_SEL ? mail_ba_reg : q_out_data;
  wire fbm_pkg::fbm_lw_t a_src_pg = PORTA_PARITY_GEN ?
    fbm_pkg::fbm_pgen(a_src, ODD_EVEN) : a_src; // R19 R22
  wire a_load = a_mail_rd || (a_q_rd && q_out_valid);

  // ******************************************************
  // parity checks
  // ******************************************************
  wire perr_a_hold = a_mail_rd && PORTA_PARITY_GEN; // R17
  wire perr_b_hold = b_mail_rd && PORTB_PARITY_GEN; // R18
  wire [3:0] b_lanes_chk = mail ? 4'hf : lanes; // R15
  wire a_bad = |fbm_pkg::fbm_perr(A_IN, ODD_EVEN); // R14
  wire b_bad = |(fbm_pkg::fbm_perr(B_IN, ODD_EVEN) & b_lanes_chk); // R14
  wire head_take = QAB_VALID && qab_ready_reg;
  wire head_v_next = head_take || (head_v_reg && !(rd_go && rd_fresh));

  // ******************************************************
  // registers
  // ******************************************************
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      size_held_reg <= fbm_pkg::SIZE_RST;
      prev_size_reg <= fbm_pkg::SIZE_RST;
      rd_size_reg <= fbm_pkg::SIZE_RST;
      wr_size_reg <= fbm_pkg::SIZE_RST;
      rd_cnt_reg <= fbm_pkg::CNT_RST;
      wr_cnt_reg <= fbm_pkg::CNT_RST;
      wr_swap_reg <= fbm_pkg::SW_NONE;
      head_v_reg <= 1'b0;
      qab_ready_reg <= 1'b0;
      a_oe_reg <= 1'b0;
      b_oe_reg <= 1'b0;
      perr_a_n_reg <= 1'b1;
      perr_b_n_reg <= 1'b1;
    end
    else
    begin
      size_held_reg <= '{code: {SIZE_SEL_HI, SIZE_SEL_LO}, big: !BIG_ENDIAN_SEL_N}; // R23
      prev_size_reg <= eff; // R8
      head_v_reg <= head_v_next;
      qab_ready_reg <= !head_v_next;
      a_oe_reg <= !PORTA_CHIP_SEL_N && !PORTA_WRITE_NREAD;
      b_oe_reg <= !PORTB_CHIP_SEL_N && !PORTB_WRITE_NREAD;
      perr_a_n_reg <= perr_a_hold || !a_bad; // R17 R14
      perr_b_n_reg <= perr_b_hold || !b_bad; // R18 R15
      if (rd_go)
      begin
        rd_size_reg <= eff;
        rd_cnt_reg <= (rk == last) ? fbm_pkg::CNT_RST : 2'(rk + 2'h1); // R2
      end
      if (wr_go)
      begin
        wr_size_reg <= eff;
        wr_swap_reg <= wswap;
        wr_cnt_reg <= commit ? fbm_pkg::CNT_RST : 2'(wk + 2'h1); // R5
      end
    end
  end

  // datapath registers carry no reset
  always_ff @(posedge CLK)
  begin
    if (head_take)
      head_reg <= QAB_DATA; // R1
    if (rd_go && rd_fresh)
      rd_word_reg <= head_pg; // R3
    if (wr_go)
      wr_asm_reg <= asm_new;
    if (a_wr && PORTA_MAIL_SEL)
      mail_ab_reg <= A_IN; // R20
    if (b_mail_wr)
      mail_ba_reg <= B_IN; // R7 R20
    if (b_mail_rd)
      b_out_reg <= mail_b_out; // R7
    else if (rd_go)
      b_out_reg <= rd_piece; // R1 R2 R4
    if (a_load)
      a_out_reg <= a_src_pg;
  end

  assign A_OUT = a_out_reg;
  assign A_OE = a_oe_reg;
  assign PORTA_PARITY_ERR_N = perr_a_n_reg;
  assign B_OUT = b_out_reg;
  assign B_OE = b_oe_reg;
  assign PORTB_PARITY_ERR_N = perr_b_n_reg;
  assign QAB_READY = qab_ready_reg;

  // ******************************************************
  // assertions
  // ******************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  size_capture_a: assert property ( // R23
    ##1 size_held_reg.code == $past({SIZE_SEL_HI, SIZE_SEL_LO})
        && size_held_reg.big == !$past(BIG_ENDIAN_SEL_N))
    else $error("size selection not captured");
  mail_keeps_size_a: assert property (mail |=> prev_size_reg == $past(prev_size_reg)) // R8
    else $error("mailbox access changed size");
  long_read_a: assert property ( // R1
    rd_go && rd_fresh && eff.code == fbm_pkg::SZ_LONG && !PORTB_PARITY_GEN
    |=> B_OUT == fbm_pkg::fbm_swap($past(head_reg), $past(swap_pins)))
    else $error("long read wrong");
  lanes_static_a: assert property ( // R4
    rd_go && eff.code == fbm_pkg::SZ_BYTE && eff.big |=> B_OUT[26:0] == $past(B_OUT[26:0]))
    else $error("unused lanes moved");
  mail_noswap_a: assert property ( // R11
    b_mail_rd && !PORTB_PARITY_GEN |=> B_OUT == $past(mail_ab_reg))
    else $error("mailbox read altered");
  flag_a_hold_a: assert property (perr_a_hold |=> PORTA_PARITY_ERR_N) // R17
    else $error("port A flag not forced");
  flag_b_hold_a: assert property (perr_b_hold |=> PORTB_PARITY_ERR_N) // R18
    else $error("port B flag not forced");
  flag_a_check_a: assert property (!perr_a_hold && a_bad |=> !PORTA_PARITY_ERR_N) // R14
    else $error("port A error missed");
  flag_b_check_a: assert property (!perr_b_hold && b_bad |=> !PORTB_PARITY_ERR_N) // R15
    else $error("port B error missed");
  new_size_wr_a: assert property ( // R6
    wr_go && wr_fresh && eff.code == fbm_pkg::SZ_BYTE |=> wr_cnt_reg == 2'h1)
    else $error("assembly not restarted");
  gen_par_a: assert property ( // R19
    a_load && PORTA_PARITY_GEN
    |=> A_OUT == fbm_pkg::fbm_pgen(A_OUT, $past(ODD_EVEN)))
    else $error("generated parity wrong");
  long_write_a: assert property ( // R5
    wr_go && eff.code == fbm_pkg::SZ_LONG
    |-> q_push_data == fbm_pkg::fbm_swap(B_IN, swap_pins))
    else $error("long write not stored whole");
  mail_intact_a: assert property ( // R22
    b_mail_rd && !(a_wr && PORTA_MAIL_SEL) |=> mail_ab_reg == $past(mail_ab_reg))
    else $error("mailbox read changed contents");
  // a mailbox access must leave both sizing counters alone
  mail_seq_hold_a: assert property ( // R8
    b_mail_rd || b_mail_wr
    |=> rd_cnt_reg == $past(rd_cnt_reg) && wr_cnt_reg == $past(wr_cnt_reg))
    else $error("mailbox access moved sizing");
  swap_held_a: assert property ( // R12
    wr_go && !wr_fresh |=> wr_swap_reg == $past(wr_swap_reg))
    else $error("write swap mode changed mid word");
  // a refused commit leaves the assembly in place for the retry
  full_retry_a: assert property ( // R5
    commit && !q_in_ready |=> wr_cnt_reg == $past(wr_cnt_reg))
    else $error("refused commit moved assembly");
  // the head register holds one word; ready drops while it is full
  head_ready_a: assert property (head_v_reg |-> !QAB_READY) // R1
    else $error("queue head offered twice");
  read_restart_a: assert property ( // R3
    rd_go && eff != rd_size_reg |=> rd_word_reg == $past(head_pg))
    else $error("new size did not reload");
  swap_rd_held_a: assert property ( // R12
    rd_go && !rd_fresh |=> rd_word_reg == $past(rd_word_reg))
    else $error("read word changed mid sequence");
  word_lanes_a: assert property ( // R4
    rd_go && eff.code == fbm_pkg::SZ_WORD && eff.big |=> B_OUT[17:0] == $past(B_OUT[17:0]))
    else $error("unused word lanes moved");
  mail_store_a: assert property (b_mail_wr |=> mail_ba_reg == $past(B_IN)) // R20
    else $error("port B mailbox write altered");
  mail_a_store_a: assert property (a_wr && PORTA_MAIL_SEL |=> mail_ab_reg == $past(A_IN)) // R20
    else $error("port A mailbox write altered");
  queue_read_a: assert property ( // R24
    a_q_rd && q_out_valid && !PORTA_PARITY_GEN |=> A_OUT == $past(q_out_data))
    else $error("queue word not delivered");
  byte_read_c: cover property (rd_go && eff.code == fbm_pkg::SZ_BYTE && rk == 2'h3);
  word_commit_c: cover property (commit && wr_go && eff.code == fbm_pkg::SZ_WORD);
  mail_mid_seq_c: cover property (b_mail_rd && rd_cnt_reg != fbm_pkg::CNT_RST);
  queue_full_c: cover property (commit && !q_in_ready);
  byte_big_rd_c: cover property (rd_go && eff.code == fbm_pkg::SZ_BYTE && eff.big);

endmodule : fbm_top

// >>> tb/fbm_qsrc.sv
// behavioural source offering long words at the a-to-b queue head
`timescale 1ns/1ps

module fbm_qsrc (
  input wire logic clk,
  input wire logic ready,
  output logic [35:0] data,
  output logic valid
);
  logic [35:0] q[$];

  initial
  begin
    data = 36'h0;
    valid = 1'b0;
  end

  // idle data flips every cycle so a stale word never looks offered
  always @(posedge clk)
  begin
    if (valid && ready)
      void'(q.pop_front());
    valid <= q.size() != 0;
    data <= (q.size() != 0) ? q[0] : ~data;
  end

  task automatic push(input logic [35:0] w);
    q.push_back(w);
  endtask : push
endmodule : fbm_qsrc

// >>> tb/testbench.sv
// self-checking bench for the port-B bus-matching, swap and parity datapath
`timescale 1ns/1ps

module testbench;
  // ****
  // signals
  // ****
  logic CLK, RST_B, ODD_EVEN, PORTA_CHIP_SEL_N, PORTA_XFER_EN, PORTA_WRITE_NREAD;
  logic PORTA_MAIL_SEL, PORTA_PARITY_GEN, A_OE, PORTA_PARITY_ERR_N, PORTB_CHIP_SEL_N;
  logic PORTB_XFER_EN, PORTB_WRITE_NREAD, SIZE_SEL_LO, SIZE_SEL_HI, BIG_ENDIAN_SEL_N;
  logic SWAP_SEL_LO, SWAP_SEL_HI, PORTB_PARITY_GEN, B_OE, PORTB_PARITY_ERR_N;
  logic QAB_VALID, QAB_READY;
  logic [35:0] A_IN, A_OUT, B_IN, B_OUT, QAB_DATA, prev;
  int n_fail = 0;
  int samples_checked = 0;
  localparam logic [8:0] BA = 9'h1a1, BB = 9'h0b2, BC = 9'h1c3, BD = 9'h0d4;
  localparam logic [35:0] W0 = {BA, BB, BC, BD};
  localparam logic [35:0] W1 = {BB, BD, BA, BC};
  typedef struct packed { logic [1:0] sw; logic pg; logic [35:0] exp; } fbm_row_t;
  fbm_row_t rows[5];
  logic [8:0] bt[4];
  logic [35:0] msk[4];

  fbm_top dut (.CLK(CLK), .RST_B(RST_B), .ODD_EVEN(ODD_EVEN),
    .PORTA_CHIP_SEL_N(PORTA_CHIP_SEL_N), .PORTA_XFER_EN(PORTA_XFER_EN),
    .PORTA_WRITE_NREAD(PORTA_WRITE_NREAD), .PORTA_MAIL_SEL(PORTA_MAIL_SEL),
    .PORTA_PARITY_GEN(PORTA_PARITY_GEN), .A_IN(A_IN), .A_OUT(A_OUT), .A_OE(A_OE),
    .PORTA_PARITY_ERR_N(PORTA_PARITY_ERR_N), .PORTB_CHIP_SEL_N(PORTB_CHIP_SEL_N),
    .PORTB_XFER_EN(PORTB_XFER_EN), .PORTB_WRITE_NREAD(PORTB_WRITE_NREAD),
    .SIZE_SEL_LO(SIZE_SEL_LO), .SIZE_SEL_HI(SIZE_SEL_HI), .BIG_ENDIAN_SEL_N(BIG_ENDIAN_SEL_N),
    .SWAP_SEL_LO(SWAP_SEL_LO), .SWAP_SEL_HI(SWAP_SEL_HI), .PORTB_PARITY_GEN(PORTB_PARITY_GEN),
    .B_IN(B_IN), .B_OUT(B_OUT), .B_OE(B_OE), .PORTB_PARITY_ERR_N(PORTB_PARITY_ERR_N),
    .QAB_DATA(QAB_DATA), .QAB_VALID(QAB_VALID), .QAB_READY(QAB_READY));
  fbm_qsrc src (.clk(CLK), .ready(QAB_READY), .data(QAB_DATA), .valid(QAB_VALID));

  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  // ****
  // helpers
  // ****
  // odd sense only: the bench keeps odd parity except in the parity loop
  function automatic logic [8:0] gen9(input logic [8:0] b);
    gen9 = {~^b[7:0], b[7:0]};
  endfunction : gen9
  function automatic logic [35:0] gen(input logic [35:0] d);
    gen = {gen9(d[35:27]), gen9(d[26:18]), gen9(d[17:9]), gen9(d[8:0])};
  endfunction : gen
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge CLK);
  endtask : tick
  task automatic idle(input int n);
    {PORTA_CHIP_SEL_N, PORTA_XFER_EN, PORTB_CHIP_SEL_N, PORTB_XFER_EN} = 4'ha;
    tick(n);
  endtask : idle
  // size pins must be captured one edge before the access that uses them
  task automatic size(input logic [1:0] sz, input logic big_n, input int n);
    {SIZE_SEL_HI, SIZE_SEL_LO, BIG_ENDIAN_SEL_N} = {sz, big_n};
    idle(n);
  endtask : size
  task automatic bop(input logic wr, input logic [1:0] sw, input logic [35:0] d);
    {PORTB_CHIP_SEL_N, PORTB_XFER_EN, PORTB_WRITE_NREAD} = {2'h1, wr};
    {SWAP_SEL_HI, SWAP_SEL_LO} = sw;
    B_IN = d;
    tick(1);
  endtask : bop
  task automatic aop(input logic wr, input logic mb, input logic [35:0] d);
    {PORTA_CHIP_SEL_N, PORTA_XFER_EN, PORTA_WRITE_NREAD, PORTA_MAIL_SEL} = {2'h1, wr, mb};
    A_IN = d;
    tick(1);
  endtask : aop
  task automatic wrap_up;
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // generous margin over a sequence of about a hundred cycles
  initial
  begin
    #100000;
    n_fail++;
    wrap_up();
  end

  initial
  begin
    {RST_B, ODD_EVEN, PORTA_MAIL_SEL, PORTA_PARITY_GEN, PORTB_PARITY_GEN} = 5'h08;
    {PORTA_WRITE_NREAD, PORTB_WRITE_NREAD, SWAP_SEL_HI, SWAP_SEL_LO} = 4'h0;
    {A_IN, B_IN} = 72'h0;
    size(2'h0, 1'b0, 3);
    chk({QAB_READY, A_OE, B_OE, PORTA_PARITY_ERR_N, PORTB_PARITY_ERR_N}, 36'h3);
    RST_B = 1'b1;
    rows = '{'{2'h0, 1'b0, W0}, '{2'h1, 1'b0, {BD, BC, BB, BA}},
      '{2'h2, 1'b0, {BC, BD, BA, BB}}, '{2'h3, 1'b0, {BB, BA, BD, BC}},
      '{2'h1, 1'b1, gen({BD, BC, BB, BA})}};
    foreach (rows[i])
    begin
      src.push(W0);
      PORTB_PARITY_GEN = rows[i].pg;
      idle(4);
      bop(1'b0, rows[i].sw, W0);
      chk(B_OUT, rows[i].exp);
      chk(B_OE, 1'b1);
      chk(QAB_READY, 1'b1);
    end
    PORTB_PARITY_GEN = 1'b0;
    src.push(W0);
    src.push(W1);
    size(2'h2, 1'b0, 4);
    prev = B_OUT;
    bop(1'b0, 2'h0, W0);
    chk(B_OUT, {BA, BB, prev[17:0]});
    bop(1'b0, 2'h0, W0);
    chk(B_OUT, {BC, BD, prev[17:0]});
    idle(3);
    bop(1'b0, 2'h0, W0);
    chk(B_OUT, {BB, BD, prev[17:0]});
    src.push(W0);
    size(2'h0, 1'b0, 4);
    bop(1'b0, 2'h0, W0);
    chk(B_OUT, W0);
    aop(1'b1, 1'b1, W1);
    src.push(W0);
    size(2'h2, 1'b0, 4);
    bop(1'b0, 2'h0, W0);
    chk(B_OUT[35:18], {BA, BB});
    size(2'h3, 1'b0, 1);
    PORTB_PARITY_GEN = 1'b1;
    bop(1'b0, 2'h1, 36'h0);
    chk(B_OUT, gen(W1));
    chk(PORTB_PARITY_ERR_N, 1'b1);
    PORTB_PARITY_GEN = 1'b0;
    bop(1'b0, 2'h1, 36'h0);
    chk(B_OUT, W1);
    size(2'h2, 1'b0, 1);
    bop(1'b0, 2'h0, W0);
    chk(B_OUT[35:18], {BC, BD});
    bt = '{BA, BB, BC, BD};
    src.push(W0);
    size(2'h1, 1'b1, 4);
    prev = B_OUT;
    for (int k = 0; k < 4; k++)
    begin
      bop(1'b0, k == 0 ? 2'h1 : 2'h2, {27'h0, gen9(9'h055)});
      chk(B_OUT, {prev[35:9], bt[k]});
      chk(PORTB_PARITY_ERR_N, 1'b1);
    end
    src.push(W0);
    size(2'h1, 1'b0, 4);
    prev = B_OUT;
    for (int k = 0; k < 4; k++)
    begin
      bop(1'b0, k == 0 ? 2'h0 : 2'h3, W0);
      chk(B_OUT, {bt[k], prev[26:0]});
    end
    size(2'h2, 1'b1, 1);
    bop(1'b1, 2'h2, {18'h3ffff, BA, BB});
    bop(1'b1, 2'h0, {18'h3ffff, BC, BD});
    size(2'h1, 1'b0, 1);
    bop(1'b1, 2'h0, {BA, 27'h0});
    size(2'h0, 1'b0, 1);
    bop(1'b1, 2'h0, W1);
    idle(2);
    aop(1'b0, 1'b0, 36'h0);
    chk(A_OUT, W0);
    chk(A_OE, 1'b1);
    aop(1'b0, 1'b0, 36'h0);
    chk(A_OUT, W1);
    idle(1);
    // fifth long word meets a full queue and must be dropped
    for (int k = 1; k < 6; k++)
      bop(1'b1, 2'h0, 36'h111111111 * k);
    idle(2);
    for (int k = 1; k < 6; k++)
    begin
      aop(1'b0, 1'b0, 36'h0);
      chk(A_OUT, 36'h111111111 * (k < 5 ? k : 4));
    end
    size(2'h3, 1'b0, 1);
    bop(1'b1, 2'h1, W1);
    PORTA_PARITY_GEN = 1'b1;
    aop(1'b0, 1'b1, 36'h0);
    chk(A_OUT, gen(W1));
    chk(PORTA_PARITY_ERR_N, 1'b1);
    PORTA_PARITY_GEN = 1'b0;
    size(2'h0, 1'b0, 1);
    msk = '{36'h0, 36'h100, 36'h0, 36'h804020100};
    for (int i = 0; i < 4; i++)
    begin
      ODD_EVEN = (i < 2);
      A_IN = gen(W0) ^ msk[i];
      B_IN = gen(W0) ^ msk[i];
      idle(2);
      chk(PORTA_PARITY_ERR_N, i == 0 || i == 3);
      chk(PORTB_PARITY_ERR_N, i == 0 || i == 3);
    end
    wrap_up();
  end
endmodule : testbench
